// >>> inc/mar_pkg.sv
// Purpose: shared constants for the multichannel converter readout block
// Assumes: core clock of 125 MHz
// Notes:   times are kept in ns and turned into cycle counts here
`default_nettype none
package mar_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS   = 8;
   localparam int CONV_TIME_NS    = 2000;
   localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CH_LIMIT_NS     = 4000;
   localparam int SWEEP_LIMIT_NS  = 12000;
   localparam int CH_LIMIT_CYC    = CH_LIMIT_NS / CLK_PERIOD_NS;
   localparam int SWEEP_LIMIT_CYC = SWEEP_LIMIT_NS / CLK_PERIOD_NS;
   // ==========================================================
   // geometry
   localparam int N_CONV       = 2;
   localparam int PINS_PER_CONV = 4;
   localparam int N_CHAN       = N_CONV * PINS_PER_CONV;
   localparam int SAMPLE_W     = 12;
   localparam int MAX_DEPTH    = 9;
   localparam int DEPTH_W      = 4;
   localparam int SUM_W        = 16;
   localparam int CNT_W        = 10;
   // ==========================================================
   // reset values
   localparam logic [3:0]  DEPTH_RST  = 4'h1;
   localparam logic [11:0] SAMPLE_RST = 12'h000;
   // ==========================================================
   // readout states
   typedef enum logic [1:0] {
      MAR_IDLE = 2'b00,
      MAR_CONV = 2'b01,
      MAR_SUM  = 2'b11,
      MAR_DONE = 2'b10
   } mar_state_t;
endpackage
`default_nettype wire

// >>> design/mar_conv.sv
// Purpose: one 12-bit converter channel with a four-pin input mux
// Assumes: pin codes are the already-quantised 0..5 V readings
// Notes:   conversion takes a fixed count of core clocks
`timescale 1ns/100ps
`default_nettype none
module mar_conv (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [1:0]  pin_sel,
   input  wire logic [47:0] pin_code,
   output logic             done,
   output logic [11:0]      result
);
   logic [mar_pkg::CNT_W-1:0] cnt;
   logic [mar_pkg::CNT_W-1:0] next_cnt;
   logic                      busy;
   logic                      next_busy;
   logic                      next_done;
   logic [11:0]               next_result;
   logic [1:0]                sel;
   logic [1:0]                next_sel;

   // ==========================================================
   // conversion timer
   always_comb begin
      next_cnt    = cnt;
      next_busy   = busy;
      next_done   = 1'b0;
      next_result = result;
      next_sel    = sel;
      if (start && !busy) begin
         next_busy = 1'b1;
         next_sel  = pin_sel;
         next_cnt  = mar_pkg::CNT_W'(mar_pkg::CONV_CYCLES - 1);
      end else if (busy) begin
         if (cnt == '0) begin
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_result = pin_code[sel*12 +: 12];
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt    <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
         result <= 12'h000;
         sel    <= 2'h0;
      end else begin
         cnt    <= next_cnt;
         busy   <= next_busy;
         done   <= next_done;
         result <= next_result;
         sel    <= next_sel;
      end
   end
endmodule
`default_nettype wire

// >>> design/mar_top.sv
// Purpose: eight-channel converter readout with per-channel moving average
// Assumes: analog inputs arrive as 12-bit codes of 0..5 V per pin
// Notes:   one request at a time; sweep runs both converters together
`timescale 1ns/100ps
`default_nettype none
module mar_top (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [95:0] ain_code,
   input  wire logic        req,
   input  wire logic        req_sweep,
   input  wire logic [2:0]  req_chan,
   input  wire logic        avg_en,
   input  wire logic [3:0]  avg_depth,
   output logic             busy,
   output logic             rd_valid,
   output logic [2:0]       rd_chan,
   output logic [11:0]      rd_data
);
   logic [11:0]        hist [mar_pkg::N_CHAN][mar_pkg::MAX_DEPTH];
   logic [3:0]         wptr [mar_pkg::N_CHAN];
   logic [3:0]         fill [mar_pkg::N_CHAN];
   mar_pkg::mar_state_t state;
   mar_pkg::mar_state_t next_state;
   logic [2:0]         cur;
   logic [2:0]         next_cur;
   logic               sweep;
   logic               next_sweep;
   logic [3:0]         depth;
   logic [3:0]         next_depth;
   logic               avg;
   logic               next_avg;
   logic [1:0]         pending;
   logic [1:0]         next_pending;
   logic [15:0]        sum;
   logic [15:0]        next_sum;
   logic [3:0]         idx;
   logic [3:0]         next_idx;
   logic [2:0]         out_q [2];
   logic [1:0]         out_n;
   logic [1:0]         next_out_n;
   logic [2:0]         next_out0;
   logic [2:0]         next_out1;
   logic               next_busy;
   logic               next_rd_valid;
   logic [2:0]         next_rd_chan;
   logic [11:0]        next_rd_data;
   logic               cv_start [2];
   logic [1:0]         cv_sel;
   logic [1:0]         cv_sel_q;
   logic               cv_done [2];
   logic [11:0]        cv_res [2];
   logic [3:0]         eff_depth;
   logic [3:0]         rd_idx;
   logic [2:0]         sum_chan;

   // ==========================================================
   // converters
   genvar g;
   generate
      for (g = 0; g < mar_pkg::N_CONV; g = g + 1) begin : g_conv
         mar_conv mar_conv_i (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .start    (cv_start[g]),
            .pin_sel  (cv_sel),
            .pin_code (ain_code[g*48 +: 48]),
            .done     (cv_done[g]),
            .result   (cv_res[g])
         );
      end
   endgenerate

   // conversion starts from a request in IDLE, or from DONE for the next sweep step
   always_comb begin
      cv_sel      = sweep ? cur[1:0] : req_chan[1:0];
      cv_start[0] = 1'b0;
      cv_start[1] = 1'b0;
      if (state == mar_pkg::MAR_IDLE && req) begin
         cv_start[0] = req_sweep || !req_chan[2];
         cv_start[1] = req_sweep || req_chan[2];
         cv_sel      = req_sweep ? 2'h0 : req_chan[1:0];
      end else if (state == mar_pkg::MAR_DONE && sweep && cur[1:0] != 2'h3 && out_n == 2'h0) begin
         cv_start[0] = 1'b1;
         cv_start[1] = 1'b1;
         cv_sel      = cur[1:0] + 2'h1;
      end
   end

   // ==========================================================
   // history buffers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int c = 0; c < mar_pkg::N_CHAN; c++) begin
            wptr[c] <= 4'h0;
            fill[c] <= 4'h0;
            for (int d = 0; d < mar_pkg::MAX_DEPTH; d++) begin
               hist[c][d] <= mar_pkg::SAMPLE_RST;
            end
         end
      end else begin
         for (int k = 0; k < mar_pkg::N_CONV; k++) begin
            if (cv_done[k]) begin
               hist[{k[0], cv_sel_q}][wptr[{k[0], cv_sel_q}]] <= cv_res[k];
               wptr[{k[0], cv_sel_q}] <= (wptr[{k[0], cv_sel_q}] == 4'(mar_pkg::MAX_DEPTH - 1))
                                         ? 4'h0 : wptr[{k[0], cv_sel_q}] + 4'h1;
               if (fill[{k[0], cv_sel_q}] != 4'(mar_pkg::MAX_DEPTH)) begin
                  fill[{k[0], cv_sel_q}] <= fill[{k[0], cv_sel_q}] + 4'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cv_sel_q <= 2'h0;
      end else if (cv_start[0] || cv_start[1]) begin
         cv_sel_q <= cv_sel;
      end
   end

   // ==========================================================
   // depth clamp and summing index
   always_comb begin
      sum_chan = out_q[0];
      if (!avg || depth == 4'h0) begin
         eff_depth = 4'h1;
      end else if (depth > 4'(mar_pkg::MAX_DEPTH)) begin
         eff_depth = 4'(mar_pkg::MAX_DEPTH);
      end else begin
         eff_depth = depth;
      end
      if (fill[sum_chan] < eff_depth && fill[sum_chan] != 4'h0) begin
         eff_depth = fill[sum_chan];
      end
      rd_idx   = (wptr[sum_chan] > idx) ? wptr[sum_chan] - idx - 4'h1
                 : 4'(mar_pkg::MAX_DEPTH) + wptr[sum_chan] - idx - 4'h1;
   end

   // ==========================================================
   // sequencing
   always_comb begin
      next_state    = state;
      next_cur      = cur;
      next_sweep    = sweep;
      next_depth    = depth;
      next_avg      = avg;
      next_pending  = pending;
      next_sum      = sum;
      next_idx      = idx;
      next_out_n    = out_n;
      next_out0     = out_q[0];
      next_out1     = out_q[1];
      next_busy     = busy;
      next_rd_valid = 1'b0;
      next_rd_chan  = rd_chan;
      next_rd_data  = rd_data;
      case (state)
         mar_pkg::MAR_IDLE: begin
            if (req) begin
               next_state   = mar_pkg::MAR_CONV;
               next_busy    = 1'b1;
               next_sweep   = req_sweep;
               next_cur     = req_sweep ? 3'h0 : req_chan;
               next_depth   = avg_depth;
               next_avg     = avg_en;
               next_pending = req_sweep ? 2'h2 : 2'h1;
            end
         end
         mar_pkg::MAR_CONV: begin
            if (cv_done[0] || cv_done[1]) begin
               next_state = mar_pkg::MAR_SUM;
               next_sum   = 16'h0000;
               next_idx   = 4'h0;
               next_out_n = next_pending;
               next_out0  = sweep ? {1'b0, cur[1:0]} : cur;
               next_out1  = {1'b1, cur[1:0]};
            end
         end
         mar_pkg::MAR_SUM: begin
            if (idx == eff_depth) begin
               next_rd_valid = 1'b1;
               next_rd_chan  = out_q[0];
               next_rd_data  = 12'(sum / 16'(eff_depth));
               next_out0     = out_q[1];
               next_out_n    = out_n - 2'h1;
               next_sum      = 16'h0000;
               next_idx      = 4'h0;
               if (out_n == 2'h1) begin
                  next_state = mar_pkg::MAR_DONE;
               end
            end else begin
               next_sum = sum + 16'(hist[sum_chan][rd_idx]);
               next_idx = idx + 4'h1;
            end
         end
         mar_pkg::MAR_DONE: begin
            if (sweep && cur[1:0] != 2'h3) begin
               next_cur   = cur + 3'h1;
               next_state = mar_pkg::MAR_CONV;
            end else begin
               next_state = mar_pkg::MAR_IDLE;
               next_busy  = 1'b0;
            end
         end
         default: begin
            next_state = mar_pkg::MAR_IDLE;
            next_busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state    <= mar_pkg::MAR_IDLE;
         cur      <= 3'h0;
         sweep    <= 1'b0;
         depth    <= mar_pkg::DEPTH_RST;
         avg      <= 1'b0;
         pending  <= 2'h0;
         sum      <= 16'h0000;
         idx      <= 4'h0;
         out_n    <= 2'h0;
         out_q[0] <= 3'h0;
         out_q[1] <= 3'h0;
         busy     <= 1'b0;
         rd_valid <= 1'b0;
         rd_chan  <= 3'h0;
         rd_data  <= 12'h000;
      end else begin
         state    <= next_state;
         cur      <= next_cur;
         sweep    <= next_sweep;
         depth    <= next_depth;
         avg      <= next_avg;
         pending  <= next_pending;
         sum      <= next_sum;
         idx      <= next_idx;
         out_n    <= next_out_n;
         out_q[0] <= next_out0;
         out_q[1] <= next_out1;
         busy     <= next_busy;
         rd_valid <= next_rd_valid;
         rd_chan  <= next_rd_chan;
         rd_data  <= next_rd_data;
      end
   end
endmodule
`default_nettype wire

// >>> sim/mar_src.sv
// Purpose: analog source model with eight pin levels as 12-bit codes
// Assumes: codes 0..4095 stand for 0..5 V
// Notes:   a level moves only when the bench sets it
`timescale 1ns/100ps
`default_nettype none
module mar_src (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        set_en,
   input  wire logic [2:0]  set_ch,
   input  wire logic [11:0] set_val,
   output logic      [95:0] ain_code
);
   // ==========================================
   // pin levels
   logic [95:0] next_ain_code;
   always_comb begin
      next_ain_code = ain_code;
      if (set_en) begin
         next_ain_code[12*set_ch +: 12] = set_val;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ain_code <= 96'h0;
      end else begin
         ain_code <= next_ain_code;
      end
   end
endmodule
`default_nettype wire

// >>> sim/mar_top_monitor.sv
// Purpose: port checks for the converter readout block
// Assumes: one clock, reset active low
// Notes:   data is checked only while pin levels hold during an operation
`timescale 1ns/100ps
`default_nettype none
module mar_top_monitor (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic [95:0] ain_code,
   input wire logic        req,
   input wire logic        req_sweep,
   input wire logic [2:0]  req_chan,
   input wire logic        avg_en,
   input wire logic [3:0]  avg_depth,
   input wire logic        busy,
   input wire logic        rd_valid,
   input wire logic [2:0]  rd_chan,
   input wire logic [11:0] rd_data
);
   localparam int CH_MAX = 499;
   localparam int SW_MAX = 1499;
   logic        sw, next_sw, avg, next_avg, moved, next_moved;
   logic [2:0]  cap_ch, next_cap_ch, cnt, next_cnt;
   logic [10:0] cyc, next_cyc;
   logic [95:0] ain_q;
   // ==========================================
   // operation tracking
   always_comb begin
      next_sw     = sw;
      next_avg    = avg;
      next_cap_ch = cap_ch;
      next_cnt    = rd_valid ? cnt + 3'h1 : cnt;
      next_cyc    = (cyc == 11'h7ff) ? cyc : cyc + 11'h1;
      next_moved  = moved || (busy && ain_code != ain_q);
      if (req && !busy) begin
         next_sw     = req_sweep;
         next_avg    = avg_en && avg_depth > 4'h1;
         next_cap_ch = req_chan;
         next_cnt    = 3'h0;
         next_cyc    = 11'h0;
         next_moved  = 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      sw     <= next_sw;
      avg    <= next_avg;
      cap_ch <= next_cap_ch;
      cnt    <= next_cnt;
      cyc    <= next_cyc;
      moved  <= next_moved;
      ain_q  <= ain_code;
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_take_busy: assert property (req && !busy |=> busy)
      else $error("busy missing after request");
   a_no_start: assert property (!busy && !req |=> !busy)
      else $error("busy without request");
   a_valid_busy: assert property (rd_valid |-> busy)
      else $error("result while idle");
   a_one_time: assert property (req && !busy && !req_sweep |-> ##[1:CH_MAX] rd_valid)
      else $error("single read too slow");
   a_sweep_time: assert property (rd_valid && sw && rd_chan == 3'h7 |-> cyc < SW_MAX)
      else $error("sweep too slow");
   a_chan_match: assert property (rd_valid && !sw |-> rd_chan == cap_ch)
      else $error("wrong result channel");
   a_sweep_order: assert property (rd_valid && sw |-> rd_chan == {cnt[0], cnt[2:1]})
      else $error("sweep order wrong");
   a_newest_data: assert property (rd_valid && !avg && !moved |-> rd_data == ain_code[12*rd_chan +: 12])
      else $error("newest sample wrong");
   a_busy_drop: assert property (rd_valid && !sw |-> ##[1:3] !busy)
      else $error("busy stuck after result");
endmodule
bind mar_top mar_top_monitor mar_top_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
   .ain_code(ain_code), .req(req), .req_sweep(req_sweep), .req_chan(req_chan),
   .avg_en(avg_en), .avg_depth(avg_depth), .busy(busy), .rd_valid(rd_valid),
   .rd_chan(rd_chan), .rd_data(rd_data));
`default_nettype wire

// >>> sim/multichannel_adc_readout_avg_bench.sv
// Purpose: self-checking bench for the converter readout block
// Assumes: 125 MHz core clock, inputs change on the falling edge
// Notes:   expected means come from a sample history kept per channel
`timescale 1ns/100ps
`default_nettype none
module multichannel_adc_readout_avg_bench;
   logic        core_clk, rst_b, req, req_sweep, avg_en, set_en, busy, rd_valid;
   logic [2:0]  req_chan, rd_chan, set_ch;
   logic [3:0]  avg_depth;
   logic [11:0] rd_data, set_val;
   logic [95:0] ain_code;
   int          mismatches = 0;
   int          checks_done = 0;
   int          hist [8][$];
   mar_top mar_top_i (.core_clk(core_clk), .rst_b(rst_b), .ain_code(ain_code), .req(req),
      .req_sweep(req_sweep), .req_chan(req_chan), .avg_en(avg_en), .avg_depth(avg_depth),
      .busy(busy), .rd_valid(rd_valid), .rd_chan(rd_chan), .rd_data(rd_data));
   mar_src mar_src_i (.core_clk(core_clk), .rst_b(rst_b), .set_en(set_en), .set_ch(set_ch),
      .set_val(set_val), .ain_code(ain_code));
   always #4 core_clk = ~core_clk;
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wait_for(input logic idle, input int lim, output int n);
      n = 0;
      while (idle ? busy !== 1'b0 : rd_valid !== 1'b1) begin
         if (n == lim) begin
            mismatches++;
            summarize();
         end
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic setv(input logic [2:0] ch, input logic [11:0] v);
      @(negedge core_clk);
      {set_en, set_ch, set_val} = {1'b1, ch, v};
      @(negedge core_clk);
      set_en = 1'b0;
   endtask
   task automatic issue(input logic [2:0] ch, input logic sw, input logic en, input logic [3:0] d);
      @(negedge core_clk);
      {req, req_sweep, req_chan, avg_en, avg_depth} = {1'b1, sw, ch, en, d};
      @(negedge core_clk);
      req = 1'b0;
   endtask
   task automatic read(input logic [2:0] ch, input logic [11:0] v, input logic en,
                       input logic [3:0] d);
      int n, k, s;
      setv(ch, v);
      hist[ch].push_back(v);
      issue(ch, 1'b0, en, d);
      wait_for(1'b0, 500, n);
      k = (en && d > 1) ? ((d > mar_pkg::MAX_DEPTH) ? mar_pkg::MAX_DEPTH : d) : 1;
      k = (k > hist[ch].size()) ? hist[ch].size() : k;
      s = 0;
      for (int i = 1; i <= k; i++) begin
         s += hist[ch][hist[ch].size() - i];
      end
      chk(rd_chan, ch);
      chk(rd_data, s / k);
      chk(n < 500, 1'b1);
      wait_for(1'b1, 20, n);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      rst_b = 1'b0;
      repeat (20) @(negedge core_clk);
      chk({busy, rd_valid, rd_chan, rd_data}, 0);
      rst_b = 1'b1;
      foreach (hist[i]) hist[i].delete();
   endtask
   task automatic t_plain();
      logic [11:0] v [8] = '{12'h000, 12'hfff, 12'h800, 12'h001,
                             12'hffe, 12'h555, 12'haaa, 12'h7ff};
      for (int c = 0; c < 8; c++) read(c[2:0], v[c], 1'b0, 4'h9);
   endtask
   task automatic t_sweep();
      int n, tot;
      logic [2:0] c;
      tot = 0;
      for (int i = 0; i < 8; i++) setv(i[2:0], 12'h1f3 * i[11:0]);
      issue(3'h0, 1'b1, 1'b0, 4'h1);
      for (int k = 0; k < 8; k++) begin
         wait_for(1'b0, 1500, n);
         tot += n + 1;
         c = {k[0], k[2:1]};
         chk(rd_chan, c);
         chk(rd_data, 12'h1f3 * c);
         @(negedge core_clk);
      end
      chk(tot < 1500, 1'b1);
      wait_for(1'b1, 20, n);
   endtask
   task automatic t_refuse();
      int n, bad;
      setv(3'h2, 12'h3c3);
      setv(3'h6, 12'h0f0);
      issue(3'h2, 1'b0, 1'b0, 4'h1);
      issue(3'h6, 1'b0, 1'b0, 4'h1);
      wait_for(1'b0, 500, n);
      chk(rd_chan, 3'h2);
      chk(rd_data, 12'h3c3);
      wait_for(1'b1, 20, n);
      bad = 0;
      repeat (300) begin
         @(negedge core_clk);
         bad += int'(busy || rd_valid);
      end
      chk(bad, 0);
   endtask
   task automatic t_avg();
      t_reset();
      for (int i = 1; i < 5; i++) begin
         read(3'h5, 12'h00a * i[11:0] * i[11:0], 1'b1, 4'h3);
         read(3'h6, 12'hfff - 12'h123 * i[11:0], 1'b1, 4'h2);
      end
      for (int i = 1; i < 12; i++) read(3'h1, 12'h16f * i[11:0], 1'b1, 4'h9);
      read(3'h1, 12'hfff, 1'b1, 4'h1);
      read(3'h1, 12'h0c8, 1'b1, 4'hf);
      read(3'h1, 12'h3e8, 1'b1, 4'h0);
      for (int d = 1; d < 10; d++) read(3'h7, 12'h1c7 * d[11:0], 1'b1, d[3:0]);
   endtask
   initial begin
      core_clk = 1'b0;
      {req, req_sweep, req_chan, avg_en, avg_depth, set_en, set_ch, set_val} = '0;
      t_reset();
      t_plain();
      t_sweep();
      t_refuse();
      t_avg();
      summarize();
   end
endmodule
`default_nettype wire
